// ---- lfd_pkg.sv ----
`default_nettype none
// Shared constants and types of the front-end command decoder.
package lfd_pkg;

  // Register file geometry.
  localparam int REG_W     = 9;
  localparam int REG_CFG_N = 7;
  localparam int ADDR_W    = 4;
  localparam int CMD_W     = 3;
  localparam int CNT_W     = 4;
  localparam int STAT_W    = 8;
  localparam int GAIN_W    = 6;
  localparam int SHIFT_W   = 15;

  // Register addresses with a special meaning.
  localparam logic [ADDR_W-1:0] ADDR_COLPAR = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;

  // Reset value of every configuration register.
  localparam logic [REG_W-1:0] CFG_RST = 9'h000;

  // Field positions in the general options register.
  localparam int CHDIS_LSB       = 1;
  localparam int CHDIS_MSB       = 3;
  localparam int ALERT_CAUSE_BIT = 4;

  // Bit counter marks within one 16-clock frame.
  localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RD_LOAD = 4'h6;
  localparam logic [CNT_W-1:0] CNT_LAST    = 4'hF;

  // Command codes carried in the top three bits of a frame.
  typedef enum logic [CMD_W-1:0] {
    CMD_CLAMP_ON  = 3'h0,
    CMD_CLAMP_OFF = 3'h1,
    CMD_SLEEP     = 3'h2,
    CMD_PRSV_ON   = 3'h3,
    CMD_PRSV_OFF  = 3'h4,
    CMD_SOFT_RST  = 3'h5,
    CMD_READ      = 3'h6,
    CMD_WRITE     = 3'h7
  } lfd_cmd_e;

  // Link direction state, one-hot.
  typedef enum logic [2:0] {
    LNK_IDLE = 3'h1,
    LNK_RECV = 3'h2,
    LNK_SEND = 3'h4
  } lfd_link_e;

  // One received frame, most significant bit first on the wire.
  typedef struct packed {
    lfd_cmd_e                cmd;
    logic [ADDR_W-1:0]       addr;
    logic [REG_W-1:0]        data;
  } lfd_frame_s;

  // Control levels handed to the analog section.
  typedef struct packed {
    logic [2:0] clamp;
    logic       sleep;
    logic       preserve;
  } lfd_ctl_s;

  // Pin levels that come from outside the clock domain.
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdio;
    logic rx_data;
  } lfd_pins_s;

endpackage
`default_nettype wire

// ---- lfd_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for the asynchronous pin levels.
module lfd_sync (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire lfd_pkg::lfd_pins_s d_i,
  output lfd_pkg::lfd_pins_s     q_o
);
  import lfd_pkg::*;

  lfd_pins_s meta_q;

  // Idle levels: chip select high, clock low, as the link rests.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0, rx_data: 1'b0};
      q_o    <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0, rx_data: 1'b0};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // lfd_sync
`default_nettype wire

// ---- lfd_parity_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// Odd row and column parity check over the configuration bank.
module lfd_parity_chk (
  input  wire logic [lfd_pkg::REG_CFG_N-1:0][lfd_pkg::REG_W-1:0] cfg_i,
  output logic                                                   perr_o
);
  import lfd_pkg::*;

  logic [REG_CFG_N-1:0] row_bad;
  logic [REG_W-1:1]     col_bad;

  // Every row must hold an odd count of ones, parity bit included.
  always_comb begin
    for (int r = 0; r < REG_CFG_N; r++) begin
      row_bad[r] = ~^cfg_i[r];
    end
  end

  // Each data column over all seven rows must also be odd.
  always_comb begin
    for (int c = 1; c < REG_W; c++) begin
      col_bad[c] = 1'b1;
      for (int r = 0; r < REG_CFG_N; r++) begin
        col_bad[c] = col_bad[c] ^ cfg_i[r][c];
      end
    end
  end

  // A cleared bank fails both checks, which is what flags reprogramming.
  assign perr_o = (|row_bad) | (|col_bad);

endmodule // lfd_parity_chk
`default_nettype wire

// ---- lfd_spi_cmd_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Data pin outputs receiver data, else input/read.
// - Frame: command, address, data byte, parity.
// - Mode 0,0: sample rising, shift falling.
// - Non-multiple of 16 clocks aborts command.
// - Clamp on enabled channels.
// - Clamp off all three channels.
// - Sleep; any other command wakes.
// - Gain preserve captures level each init.
// - Preserve off resumes normal tracking.
// - Soft reset only in active state.
// - Clamp stays engaged across soft reset.
// - Command-only frames ignore address and data.
// - Read returns register, write stores it.
// - Status register read-only, writes ignored.
// - Bit 0 is odd row parity.
// - Register six holds column parity.
// - Clock pin is open-collector alert when idle.
// - Reset clears registers, alert flags parity.
module lfd_spi_cmd_decoder (
  input  wire logic                                              clk_i,
  input  wire logic                                              rst_n_i,
  input  wire logic                                              cs_n_i,
  input  wire logic                                              sclk_i,
  input  wire logic                                              sdio_i,
  input  wire logic                                              rx_data_i,
  input  wire logic                                              active_mode_i,
  input  wire logic                                              alarm_i,
  input  wire logic                                              gain_init_i,
  input  wire logic [lfd_pkg::GAIN_W-1:0]                        gain_level_i,
  input  wire logic [lfd_pkg::STAT_W-1:0]                        status_i,
  output logic                                                   sdio_o,
  output logic                                                   sdio_oe_o,
  output logic                                                   alert_o,
  output logic                                                   alert_oe_o,
  output lfd_pkg::lfd_ctl_s                                      ctl_o,
  output logic                                                   soft_reset_o,
  output logic [lfd_pkg::GAIN_W-1:0]                             gain_hold_o,
  output logic [lfd_pkg::REG_CFG_N-1:0][lfd_pkg::REG_W-1:0]      cfg_o
);
  import lfd_pkg::*;

  lfd_pins_s                         pins_raw;
  lfd_pins_s                         pins_s;
  logic                              sclk_d_q;
  logic                              cs_d_q;
  logic                              sclk_rise;
  logic                              sclk_fall;
  logic                              cs_rise;
  logic                              cs_fall;
  logic [CNT_W-1:0]                  cnt_q;
  logic [SHIFT_W-1:0]                shift_q;
  logic                              frame_done;
  lfd_frame_s                        new_frame;
  lfd_frame_s                        pend_q;
  logic                              pend_v_q;
  logic                              exec_v;
  lfd_link_e                         state_q;
  logic                              rd_load;
  logic [REG_W-1:0]                  tx_q;
  logic                              sdio_q;
  logic [REG_CFG_N-1:0][REG_W-1:0]   cfg_q;
  logic                              perr;
  logic [REG_W-1:0]                  status_word;
  logic [REG_W-1:0]                  rd_word;
  logic [2:0]                        clamp_q;
  logic                              sleep_q;
  logic                              preserve_q;
  logic                              soft_q;
  logic [GAIN_W-1:0]                 gain_q;

  // Register read mux; unmapped addresses read as zero.
  function automatic logic [REG_W-1:0] read_reg(
    input logic [ADDR_W-1:0]               addr,
    input logic [REG_CFG_N-1:0][REG_W-1:0] bank,
    input logic [REG_W-1:0]                stat
  );
    logic [REG_W-1:0] val;
    val = '0;
    if (addr == ADDR_STATUS) begin
      val = stat;
    end else if (addr < ADDR_STATUS) begin
      val = bank[addr[2:0]];
    end
    return val;
  endfunction

  // All link pins come from the master's domain and are synchronised first.
  assign pins_raw = '{cs_n: cs_n_i, sclk: sclk_i, sdio: sdio_i, rx_data: rx_data_i};

  lfd_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (pins_raw),
    .q_o     (pins_s)
  );

  lfd_parity_chk u_parity (
    .cfg_i  (cfg_q),
    .perr_o (perr)
  );

  // Delayed copies of the synchronised levels for edge detection.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_d_q <= 1'b0;
      cs_d_q   <= 1'b1;
    end else begin
      sclk_d_q <= pins_s.sclk;
      cs_d_q   <= pins_s.cs_n;
    end
  end

  // Clock edges count only while selected, so alert traffic is never decoded.
  assign sclk_rise = !pins_s.cs_n && pins_s.sclk && !sclk_d_q;
  assign sclk_fall = !pins_s.cs_n && !pins_s.sclk && sclk_d_q;
  assign cs_rise   = pins_s.cs_n && !cs_d_q;
  assign cs_fall   = !pins_s.cs_n && cs_d_q;

  // Bit counter wraps every 16 clocks; zero at deselect means whole frames.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= CNT_ZERO;
    end else if (cs_fall) begin
      cnt_q <= CNT_ZERO;
    end else if (sclk_rise) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Input shifter, most significant bit arrives first.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[SHIFT_W-2:0], pins_s.sdio};
    end
  end

  assign frame_done = sclk_rise && (cnt_q == CNT_LAST);
  assign new_frame  = lfd_frame_s'({shift_q, pins_s.sdio});

  // A finished frame waits here; it runs once the next frame completes or
  // chip select rises on a 16-clock boundary. A ragged tail is dropped.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_q   <= '0;
      pend_v_q <= 1'b0;
    end else if (frame_done) begin
      pend_q   <= new_frame;
      pend_v_q <= 1'b1;
    end else if (cs_rise || cs_fall) begin
      pend_v_q <= 1'b0;
    end
  end

  assign exec_v = pend_v_q && (frame_done || (cs_rise && (cnt_q == CNT_ZERO)));

  // Read data is loaded after the seventh bit, so it fills the data slots.
  assign rd_load = sclk_rise && (cnt_q == CNT_RD_LOAD)
                   && (lfd_cmd_e'(shift_q[5:3]) == CMD_READ);

  // Pin direction sequencer.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= LNK_IDLE;
    end else if (pins_s.cs_n) begin
      state_q <= LNK_IDLE;
    end else begin
      case (state_q)
        LNK_IDLE: begin
          state_q <= LNK_RECV;
        end
        LNK_RECV: begin
          if (rd_load) begin
            state_q <= LNK_SEND;
          end
        end
        LNK_SEND: begin
          if (frame_done) begin
            state_q <= LNK_RECV;
          end
        end
        default: begin
          state_q <= LNK_IDLE;
        end
      endcase
    end
  end

  // Status word and the addressed read value, taken into the shifter at the seventh bit.
  assign status_word = {status_i, perr};
  assign rd_word     = read_reg({shift_q[2:0], pins_s.sdio}, cfg_q, status_word);

  // Output shifter advances on falling clock edges only.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_q <= '0;
    end else if (rd_load) begin
      tx_q <= rd_word;
    end else if (sclk_fall && (state_q == LNK_SEND)) begin
      tx_q <= {tx_q[REG_W-2:0], 1'b0};
    end
  end

  // Data pin level: receiver data while idle, read bits during a read.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sdio_q <= 1'b0;
    end else if (pins_s.cs_n) begin
      sdio_q <= pins_s.rx_data;
    end else if (sclk_fall && (state_q == LNK_SEND)) begin
      sdio_q <= tx_q[REG_W-1];
    end
  end

  assign sdio_o    = sdio_q;
  assign sdio_oe_o = pins_s.cs_n || (state_q == LNK_SEND);

  // Alert pulls low only while deselected; the pin is the clock otherwise.
  assign alert_o    = 1'b0;
  assign alert_oe_o = pins_s.cs_n
                      && (perr || (cfg_q[0][ALERT_CAUSE_BIT] && alarm_i));

  // Configuration bank; status is built from live inputs and is never stored.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int r = 0; r < REG_CFG_N; r++) begin
        cfg_q[r] <= CFG_RST;
      end
    end else if (exec_v && (pend_q.cmd == CMD_WRITE) && (pend_q.addr < ADDR_STATUS)) begin
      cfg_q[pend_q.addr[2:0]] <= pend_q.data;
    end
  end

  // Clamp levels; a soft reset does not touch them.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clamp_q <= '0;
    end else if (exec_v && (pend_q.cmd == CMD_CLAMP_ON)) begin
      clamp_q <= ~cfg_q[0][CHDIS_MSB:CHDIS_LSB];
    end else if (exec_v && (pend_q.cmd == CMD_CLAMP_OFF)) begin
      clamp_q <= '0;
    end
  end

  // Sleep is left by any other command that actually executes.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sleep_q <= 1'b0;
    end else if (exec_v) begin
      sleep_q <= (pend_q.cmd == CMD_SLEEP);
    end
  end

  // Gain preserve mode.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      preserve_q <= 1'b0;
    end else if (exec_v && (pend_q.cmd == CMD_PRSV_ON)) begin
      preserve_q <= 1'b1;
    end else if (exec_v && (pend_q.cmd == CMD_PRSV_OFF)) begin
      preserve_q <= 1'b0;
    end
  end

  // Soft reset pulse, gated by the active power state.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= exec_v && (pend_q.cmd == CMD_SOFT_RST) && active_mode_i;
    end
  end

  // Held gain level: cleared by soft reset, recaptured at each init period while preserve is on.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gain_q <= '0;
    end else if (soft_q) begin
      gain_q <= '0;
    end else if (preserve_q && gain_init_i) begin
      gain_q <= gain_level_i;
    end
  end

  assign ctl_o        = '{clamp: clamp_q, sleep: sleep_q, preserve: preserve_q};
  assign soft_reset_o = soft_q;
  assign gain_hold_o  = gain_q;
  assign cfg_o        = cfg_q;

  // Checks kept next to the logic they guard.
  chk_sdio_input_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!pins_s.cs_n && (state_q != LNK_SEND)) |-> !sdio_oe_o)
    else $error("Data pin driven while receiving.");

  chk_read_drive_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_load |=> (sdio_oe_o && (tx_q == $past(rd_word))))
    else $error("Read did not load the addressed register.");

  chk_abort_frame: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cs_rise && (cnt_q != CNT_ZERO)) |-> !exec_v)
    else $error("Ragged frame executed.");

  chk_abort_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cs_rise && (cnt_q != CNT_ZERO)) |=> ($stable(cfg_q) && $stable(ctl_o)))
    else $error("Aborted frame changed state.");

  chk_clamp_on_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (exec_v && (pend_q.cmd == CMD_CLAMP_ON))
    |=> (ctl_o.clamp == ~$past(cfg_q[0][CHDIS_MSB:CHDIS_LSB])))
    else $error("Clamp on ignored channel enables.");

  chk_clamp_off_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (exec_v && (pend_q.cmd == CMD_CLAMP_OFF)) |=> (ctl_o.clamp == 3'h0))
    else $error("Clamp off left a channel clamped.");

  chk_sleep_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (exec_v && (pend_q.cmd != CMD_SLEEP)) |=> !ctl_o.sleep)
    else $error("Device stayed asleep after a command.");

  chk_preserve_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctl_o.preserve && gain_init_i && !soft_q) |=> (gain_hold_o == $past(gain_level_i)))
    else $error("Gain level not captured.");

  chk_preserve_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (exec_v && (pend_q.cmd == CMD_PRSV_OFF)) |=> !ctl_o.preserve ##1 !ctl_o.preserve)
    else $error("Preserve stayed on.");

  chk_soft_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_reset_o |-> ($past(exec_v) && ($past(pend_q.cmd) == CMD_SOFT_RST)
                      && $past(active_mode_i)))
    else $error("Soft reset outside active state.");

  chk_soft_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_reset_o |-> (ctl_o.clamp == $past(ctl_o.clamp, 2)))
    else $error("Soft reset dropped the clamp.");

  chk_write_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (exec_v && (pend_q.cmd == CMD_WRITE) && (pend_q.addr < ADDR_STATUS))
    |=> (cfg_q[$past(pend_q.addr[2:0])] == $past(pend_q.data)))
    else $error("Write data not stored.");

  chk_status_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (exec_v && (pend_q.cmd == CMD_WRITE) && (pend_q.addr >= ADDR_STATUS))
    |=> $stable(cfg_q))
    else $error("Write to status changed the bank.");

  chk_alert_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pins_s.cs_n && perr) |-> (alert_oe_o && !alert_o) ##1 (!pins_s.cs_n || alert_oe_o || !perr))
    else $error("Alert not pulled on parity error.");

  chk_alert_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !pins_s.cs_n |-> !alert_oe_o)
    else $error("Alert driven while clock is an input.");

endmodule // lfd_spi_cmd_decoder
`default_nettype wire

// ---- lfd_spi_master.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behavioural serial master standing in for the microcontroller on the link pins.
module lfd_spi_master (
  input  wire logic clk_i,
  input  wire logic sdio_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdio_o
);

  // The link idles deselected with the clock low.
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdio_o = 1'b0;
  end

  // Sends the top nclk bits of w, most significant first, and captures the pin
  // at every rising edge. Pins move only on falling edges of the system clock,
  // and a half period of four system clocks gives a 200 ns link clock.
  // Past sixteen clocks the bit index wraps round to the top of w.
  task automatic xfer(input logic [15:0] w, input int nclk, output logic [15:0] rd);
    logic rd_cmd;
    rd_cmd = (w[15:13] == 3'h6);
    rd = 16'h0000;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 15; i > 15 - nclk; i--) begin
      // Read slots are released; a toggling level exposes a missed turnaround.
      sdio_o = (rd_cmd && i <= 8) ? ~sdio_o : w[i[3:0]];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      rd[i[3:0]] = sdio_i;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
  endtask

endmodule // lfd_spi_master
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the command decoder driven through its serial pins.
module tb;
  import lfd_pkg::*;

  logic                            clk_i       = 1'b0;
  logic                            rst_n_i     = 1'b0;
  logic                            rx_data     = 1'b0;
  logic                            active_mode = 1'b0;
  logic                            alarm       = 1'b0;
  logic                            gain_init   = 1'b0;
  logic [GAIN_W-1:0]               gain_level  = 6'h00;
  logic [STAT_W-1:0]               status      = 8'h00;
  logic                            m_cs_n;
  logic                            m_sclk;
  logic                            m_sdio;
  logic                            sdio_pin;
  logic                            sclk_pin;
  logic                            dut_sdio;
  logic                            dut_sdio_oe;
  logic                            alert;
  logic                            alert_oe;
  logic                            soft_reset;
  lfd_ctl_s                        ctl;
  logic [GAIN_W-1:0]               gain_hold;
  logic [REG_CFG_N-1:0][REG_W-1:0] cfg;
  logic [REG_CFG_N-1:0][REG_W-1:0] exp_cfg;
  logic [7:0]                      col;
  logic [15:0]                     rd;
  int                              err_total = 0;
  int                              checked   = 0;
  int                              sr_cnt    = 0;

  // The system clock runs at 40 MHz.
  always #12.5 clk_i = ~clk_i;

  // The decoder wins the data pin while it drives; the alert pulls the clock pin low.
  assign sdio_pin = dut_sdio_oe ? dut_sdio : m_sdio;
  assign sclk_pin = alert_oe ? 1'b0 : m_sclk;

  lfd_spi_master i_lfd_spi_master (
    .clk_i  (clk_i),
    .sdio_i (sdio_pin),
    .cs_n_o (m_cs_n),
    .sclk_o (m_sclk),
    .sdio_o (m_sdio)
  );

  lfd_spi_cmd_decoder i_lfd_spi_cmd_decoder (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .cs_n_i        (m_cs_n),
    .sclk_i        (sclk_pin),
    .sdio_i        (sdio_pin),
    .rx_data_i     (rx_data),
    .active_mode_i (active_mode),
    .alarm_i       (alarm),
    .gain_init_i   (gain_init),
    .gain_level_i  (gain_level),
    .status_i      (status),
    .sdio_o        (dut_sdio),
    .sdio_oe_o     (dut_sdio_oe),
    .alert_o       (alert),
    .alert_oe_o    (alert_oe),
    .ctl_o         (ctl),
    .soft_reset_o  (soft_reset),
    .gain_hold_o   (gain_hold),
    .cfg_o         (cfg)
  );

  // Soft reset is a one-cycle pulse, so it is counted rather than sampled.
  always @(posedge clk_i) begin
    if (soft_reset === 1'b1) begin
      sr_cnt <= sr_cnt + 1;
    end
  end

  // Prints the verdict and ends the run.
  task automatic results;
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic compare_bank(input string what);
    for (int i = 0; i < REG_CFG_N; i++) begin
      compare(16'(cfg[i]), 16'(exp_cfg[i]), what);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Odd row parity in bit 0 over the data byte above it.
  function automatic logic [REG_W-1:0] par(input logic [7:0] b);
    return {b, ~^b};
  endfunction

  // A write executes at deselect, so a few clocks are left for it to land.
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    i_lfd_spi_master.xfer({3'h7, a, d}, 16, rd);
    idle(8);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [8:0] e);
    i_lfd_spi_master.xfer({3'h6, a, 9'h000}, 16, rd);
    idle(8);
    compare(16'(rd[8:0]), 16'(e), "read data");
  endtask

  // Address, data and parity slots carry ones that must be ignored.
  task automatic cmd(input lfd_cmd_e c);
    i_lfd_spi_master.xfer({c, 4'hF, 9'h1FF}, 16, rd);
    idle(8);
  endtask

  task automatic gain_pulse(input logic [GAIN_W-1:0] g);
    gain_level = g;
    gain_init = 1'b1;
    idle(1);
    gain_init = 1'b0;
    idle(2);
  endtask

  // Main sequence: reset, configuration, refusals, alert and every command.
  initial begin
    idle(8);
    rst_n_i = 1'b1;
    idle(4);
    exp_cfg = '0;
    compare_bank("cfg after reset");
    compare(16'(alert_oe), 16'h1, "alert on cleared bank");
    compare(16'(dut_sdio_oe), 16'h1, "data pin drives when idle");
    compare(16'(ctl), 16'h0, "controls after reset");
    rx_data = 1'b1;
    idle(4);
    compare(16'(dut_sdio), 16'h1, "receiver data high");
    rx_data = 1'b0;
    idle(4);
    compare(16'(dut_sdio), 16'h0, "receiver data low");
    // A consistent bank: odd rows and odd columns clear the parity alert.
    exp_cfg[0] = par(8'h0A);
    exp_cfg[1] = par(8'h5C);
    exp_cfg[2] = par(8'hA3);
    exp_cfg[3] = par(8'h3F);
    exp_cfg[4] = par(8'h81);
    exp_cfg[5] = par(8'hE7);
    col = 8'hFF;
    for (int i = 0; i < 6; i++) begin
      col = col ^ exp_cfg[i][8:1];
    end
    exp_cfg[6] = par(col);
    for (int i = 0; i < REG_CFG_N; i++) begin
      wr(4'(i), exp_cfg[i]);
    end
    compare_bank("cfg after writes");
    for (int i = 0; i < REG_CFG_N; i++) begin
      rdchk(4'(i), exp_cfg[i]);
    end
    compare(16'(alert_oe), 16'h0, "alert with good parity");
    status = 8'hA5;
    rdchk(4'h7, {8'hA5, 1'b0});
    wr(4'h7, 9'h1FF);
    wr(4'h9, 9'h155);
    compare_bank("cfg after refused writes");
    rdchk(4'h7, {8'hA5, 1'b0});
    rdchk(4'h9, 9'h000);
    // A whole frame plus one stray clock: the pending frame must be dropped.
    i_lfd_spi_master.xfer({3'h7, 4'h1, 9'h000}, 17, rd);
    idle(8);
    compare_bank("cfg after ragged write");
    i_lfd_spi_master.xfer({3'h0, 4'h0, 9'h000}, 17, rd);
    idle(8);
    compare(16'(ctl.clamp), 16'h0, "clamp after ragged frame");
    // Alarm cause bit of the general options is set in the bank above.
    alarm = 1'b1;
    idle(3);
    compare(16'(alert_oe), 16'h1, "alert on alarm");
    alarm = 1'b0;
    idle(3);
    compare(16'(alert_oe), 16'h0, "alert released");
    compare(16'(alert), 16'h0, "alert level");
    cmd(CMD_CLAMP_ON);
    compare(16'(ctl.clamp), 16'({~exp_cfg[0][3:1]}), "clamp on");
    cmd(CMD_CLAMP_OFF);
    compare(16'(ctl.clamp), 16'h0, "clamp off");
    cmd(CMD_SLEEP);
    compare(16'(ctl.sleep), 16'h1, "sleep");
    cmd(CMD_PRSV_ON);
    compare(16'(ctl.sleep), 16'h0, "wake");
    compare(16'(ctl.preserve), 16'h1, "preserve on");
    gain_pulse(6'h2B);
    compare(16'(gain_hold), 16'h2B, "gain captured");
    cmd(CMD_CLAMP_ON);
    cmd(CMD_SOFT_RST);
    compare(16'(sr_cnt), 16'h0, "soft reset when not active");
    compare(16'(gain_hold), 16'h2B, "gain kept");
    active_mode = 1'b1;
    cmd(CMD_SOFT_RST);
    compare(16'(sr_cnt), 16'h1, "soft reset pulse");
    compare(16'(gain_hold), 16'h0, "gain cleared");
    compare(16'(ctl.clamp), 16'({~exp_cfg[0][3:1]}), "clamp kept");
    gain_pulse(6'h11);
    compare(16'(gain_hold), 16'h11, "gain recaptured");
    cmd(CMD_PRSV_OFF);
    compare(16'(ctl.preserve), 16'h0, "preserve off");
    gain_pulse(6'h3F);
    compare(16'(gain_hold), 16'h11, "gain not captured");
    results();
  end

  // About thirty frames of some 140 clocks each; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end

endmodule // tb
`default_nettype wire
